/* File: core/pcs_consts.svh */
// constants of the program counter, return stack and indirect addressing block
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_PC_W 13
`define PCS_LOW_W 8
`define PCS_UP_W 5
`define PCS_PAGE_W 2
`define PCS_JUMP_W 11
`define PCS_HOLD_PAGE_LSB 3
`define PCS_HOLD_UP_MSB 4
`define PCS_STACK_DEPTH 8
`define PCS_FP_W 8
`define PCS_EA_W 9
`define PCS_PC_RST 13'h0000
`define PCS_HOLD_RST 5'h00
`define PCS_FP_RST 8'h00
`define PCS_ZERO_BYTE 8'h00
`define PCS_IND_SELF 8'h00
`define PCS_PC_STEP 13'h0001
`define PCS_IRQ_VEC 13'h0004
`endif

/* File: core/pcs_pkg.sv */
// types shared by the program counter and return stack logic
package pcs_pkg;
   typedef logic [12:0] pcs_pc_t;
   typedef logic [7:0] pcs_byte_t;
   // source of the next program counter value
   typedef enum logic [2:0]
   {
      PCS_SRC_HOLD = 3'h0,
      PCS_SRC_SEQ = 3'h1,
      PCS_SRC_JUMP = 3'h3,
      PCS_SRC_VEC = 3'h2,
      PCS_SRC_POP = 3'h6,
      PCS_SRC_LOW = 3'h7
   } pcs_src_e;
endpackage

/* File: core/pcs_core.sv */
// program counter, circular return stack and indirect address former
`timescale 1ns/10ps
`include "pcs_consts.svh"
//--------------------------------------------------------------
// Behaviour
// RQ1 - 13-bit counter, low byte read and write
// RQ2 - upper five bits unreadable, set via holding
// RQ3 - any reset clears upper counter bits
// RQ4 - low byte write loads upper from holding
// RQ5 - call/jump: 11 instruction bits, two page bits
// RQ6 - 8K space split into 2K pages
// RQ7 - software sets page bits before far branch
// RQ8 - eight by 13-bit stack, hidden pointer
// RQ9 - call or interrupt pushes whole counter
// RQ10 - returns pop stack into whole counter
// RQ11 - push and pop leave holding register alone
// RQ12 - ninth push overwrites first entry
// RQ13 - no overflow or underflow indication
// RQ14 - software avoids tables crossing 256 blocks
// RQ15 - indirect port accesses register at pointer
// RQ16 - indirect read of itself returns zero
// RQ17 - indirect write of itself stores nothing
// RQ18 - 9-bit address: bank bit over pointer
// RQ19 - sequential fetch increments counter, wraps
//--------------------------------------------------------------
module pcs_core
   import pcs_pkg::*;
#(
   parameter int STACK_DEPTH = `PCS_STACK_DEPTH,
   parameter logic [12:0] IRQ_VECTOR = `PCS_IRQ_VEC
)
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic fetchAdvance,
   input wire logic pcLowWrEn,
   input wire logic [7:0] pcLowWrData,
   input wire logic pcHoldWrEn,
   input wire logic [7:0] pcHoldWrData,
   input wire logic jumpEn,
   input wire logic callEn,
   input wire logic [10:0] jumpTarget,
   input wire logic irqBranch,
   input wire logic returnEn,
   input wire logic filePtrWrEn,
   input wire logic [7:0] filePtrWrData,
   input wire logic indirectBankBit,
   input wire logic indRdEn,
   input wire logic indWrEn,
   input wire logic [7:0] fileRdData,
   output logic [12:0] progAddr,
   output logic [7:0] pcLowByte,
   output logic [4:0] pcHoldingOut,
   output logic [7:0] filePtrOut,
   output logic [8:0] effAddr,
   output logic fileRdEn,
   output logic fileWrEn,
   output logic [7:0] indRdData
);
   localparam int PTR_W = $clog2(STACK_DEPTH);
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

   // the pointer wraps by plain binary overflow, so depth must be a power of two;
   // the check runs at elaboration so a bad depth never builds
   if (STACK_DEPTH < 2 || (1 << PTR_W) != STACK_DEPTH)
   begin
      $error("stack depth must be a power of two of at least two");
   end

   //--------------------------------------------------------------
   // program counter
   //--------------------------------------------------------------
   pcs_pc_t pcQ;
   pcs_pc_t pcD;
   pcs_src_e srcSel;
   logic [`PCS_UP_W-1:0] holdQ;
   logic [PTR_W-1:0] stkPtrQ;
   pcs_pc_t stackMem [STACK_DEPTH];
   logic pushEn;
   logic popEn;
   pcs_pc_t popValue;

   // a write to the low byte wins over any branch in the same cycle,
   // then interrupt, call or jump, return and plain fetch
   always_comb
   begin
      if (pcLowWrEn)
      begin
         srcSel = PCS_SRC_LOW;
      end
      else if (irqBranch)
      begin
         srcSel = PCS_SRC_VEC;
      end
      else if (jumpEn || callEn)
      begin
         srcSel = PCS_SRC_JUMP;
      end
      else if (returnEn)
      begin
         srcSel = PCS_SRC_POP;
      end
      else if (fetchAdvance)
      begin
         srcSel = PCS_SRC_SEQ;
      end
      else
      begin
         srcSel = PCS_SRC_HOLD;
      end
   end

   // next counter value for each source
   always_comb
   begin
      case (srcSel)
         PCS_SRC_LOW: pcD = {holdQ, pcLowWrData}; // RQ4 RQ1
         PCS_SRC_VEC: pcD = IRQ_VECTOR;
         PCS_SRC_JUMP: pcD = {holdQ[`PCS_HOLD_UP_MSB:`PCS_HOLD_PAGE_LSB], jumpTarget}; // RQ5 RQ6
         PCS_SRC_POP: pcD = popValue; // RQ10
         PCS_SRC_SEQ: pcD = pcQ + `PCS_PC_STEP; // RQ19
         default: pcD = pcQ;
      endcase
   end

   // counter register; reset clears the upper bits with the rest
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pcQ <= `PCS_PC_RST; // RQ3
      end
      else
      begin
         pcQ <= pcD;
      end
   end

   // only the low byte is visible to software
   assign pcLowByte = pcQ[`PCS_LOW_W-1:0]; // RQ1 RQ2
   assign progAddr = pcQ;

   //--------------------------------------------------------------
   // high holding register
   //--------------------------------------------------------------
   // only software writes change it; stack traffic never does
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         holdQ <= `PCS_HOLD_RST;
      end
      else if (pcHoldWrEn)
      begin
         holdQ <= pcHoldWrData[`PCS_HOLD_UP_MSB:0]; // RQ11
      end
   end

   assign pcHoldingOut = holdQ;

   //--------------------------------------------------------------
   // return stack
   //--------------------------------------------------------------
   // push on an accepted call or interrupt, pop on an accepted return
   assign pushEn = (srcSel == PCS_SRC_VEC) || (srcSel == PCS_SRC_JUMP && callEn); // RQ9
   assign popEn = (srcSel == PCS_SRC_POP); // RQ10
   assign popValue = stackMem[stkPtrQ - PTR_ONE];

   // pointer wraps silently; no overflow or underflow flag exists
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stkPtrQ <= '0;
      end
      else if (pushEn)
      begin
         stkPtrQ <= stkPtrQ + PTR_ONE; // RQ12 RQ13
      end
      else if (popEn)
      begin
         stkPtrQ <= stkPtrQ - PTR_ONE; // RQ12 RQ13
      end
   end

   // storage holds no reset so it maps onto plain memory cells
   always_ff @(posedge clk_sys)
   begin
      if (pushEn)
      begin
         stackMem[stkPtrQ] <= pcQ; // RQ8 RQ9
      end
   end

   //--------------------------------------------------------------
   // indirect addressing
   //--------------------------------------------------------------
   logic [`PCS_FP_W-1:0] fpQ;
   logic selfTarget;

   // file pointer register
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fpQ <= `PCS_FP_RST;
      end
      else if (filePtrWrEn)
      begin
         fpQ <= filePtrWrData;
      end
   end

   assign filePtrOut = fpQ;
   assign effAddr = {indirectBankBit, fpQ}; // RQ18 RQ15
   assign selfTarget = (fpQ == `PCS_IND_SELF);

   // an access that points back at the port itself touches nothing;
   // status flags are the datapath's business and stay unaffected here
   assign fileRdEn = indRdEn && !selfTarget; // RQ15 RQ16
   assign fileWrEn = indWrEn && !selfTarget; // RQ17

   // read data is registered, one cycle after the request
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         indRdData <= `PCS_ZERO_BYTE;
      end
      else if (indRdEn)
      begin
         indRdData <= selfTarget ? `PCS_ZERO_BYTE : fileRdData; // RQ16 RQ15
      end
   end

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   // a low byte write carries the holding bits up
   a_low_write_load: // RQ4
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      pcLowWrEn |=> pcQ == {$past(holdQ), $past(pcLowWrData)})
   else $error("low byte write did not load counter from holding");

   // checked while reset is low, so no disable here
   a_reset_clear: // RQ3
   assert property (@(posedge clk_sys)
      !arst_n |-> pcQ[`PCS_PC_W-1:`PCS_LOW_W] == '0)
   else $error("upper counter bits not cleared in reset");

   // branches keep only the two page bits of the holding register
   a_jump_page_bits: // RQ5
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      (jumpEn || callEn) && !pcLowWrEn && !irqBranch
      |=> pcQ == {$past(holdQ[`PCS_HOLD_UP_MSB:`PCS_HOLD_PAGE_LSB]), $past(jumpTarget)})
   else $error("branch target not built from page bits");

   // a push stores the counter at the free slot
   a_call_push: // RQ9
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      pushEn |=> stkPtrQ == $past(stkPtrQ) + PTR_ONE && stackMem[$past(stkPtrQ)] == $past(pcQ))
   else $error("push did not store the counter");

   // a call followed straight by a return comes home
   a_call_return_trip: // RQ10
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      (callEn && srcSel == PCS_SRC_JUMP) ##1 (popEn && !pushEn) |=> pcQ == $past(pcQ, 2))
   else $error("return did not restore the pushed counter");

   // stack traffic must not disturb the holding bits
   a_hold_untouched: // RQ11
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      (pushEn || popEn) && !pcHoldWrEn |=> $stable(holdQ))
   else $error("stack traffic changed holding register");

   // eight pushes in a row bring the pointer back round
   a_ptr_wrap: // RQ12
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      (pushEn && !popEn) [*8] |=> stkPtrQ == $past(stkPtrQ, 8))
   else $error("stack pointer did not wrap after eight pushes");

   // the port pointing at itself reads as zero
   a_self_read_zero: // RQ16
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      indRdEn && selfTarget |-> !fileRdEn ##1 indRdData == `PCS_ZERO_BYTE)
   else $error("indirect self read did not return zero");

   // a write to the port itself reaches nothing
   a_self_write_drop: // RQ17
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      indWrEn |-> fileWrEn == (fpQ != `PCS_IND_SELF))
   else $error("indirect self write was passed on");

   // the bank bit sits above the pointer
   a_pointer_address: // RQ18
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      filePtrWrEn |=> effAddr[`PCS_FP_W-1:0] == $past(filePtrWrData) && effAddr[`PCS_EA_W-1] == indirectBankBit)
   else $error("effective address not pointer under bank bit");

   // plain fetch steps by one and wraps
   a_seq_increment: // RQ19
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      srcSel == PCS_SRC_SEQ |=> pcQ == $past(pcQ) + `PCS_PC_STEP)
   else $error("sequential fetch did not advance counter by one");

   // an interrupt loads the vector and saves where it left off
   a_irq_vector_load: // RQ9
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      irqBranch && !pcLowWrEn |=> pcQ == IRQ_VECTOR && stackMem[$past(stkPtrQ)] == $past(pcQ))
   else $error("interrupt branch did not load vector and push");

   // after a pop the counter matches the slot just freed
   a_pop_restore: // RQ10
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      popEn |=> stkPtrQ == $past(stkPtrQ) - PTR_ONE && pcQ == stackMem[stkPtrQ])
   else $error("return did not load the popped entry");

   // the visible low byte follows a software write
   a_low_byte_view: // RQ1
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      pcLowWrEn |=> pcLowByte == $past(pcLowWrData))
   else $error("low byte did not show the written value");

   // only the kept bits of a holding write appear
   a_hold_write: // RQ2
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      pcHoldWrEn |=> pcHoldingOut == $past(pcHoldWrData[`PCS_HOLD_UP_MSB:0]))
   else $error("holding register did not take the write");

   // without a push or pop the hidden pointer stays put
   a_ptr_idle: // RQ8
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      !pushEn && !popEn |=> $stable(stkPtrQ))
   else $error("stack pointer moved without push or pop");

   // a real indirect read passes the file data through
   a_read_capture: // RQ15
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      indRdEn && !selfTarget |-> fileRdEn ##1 indRdData == $past(fileRdData))
   else $error("indirect read did not return file data");

   // the pointer changes only when software writes it
   a_pointer_hold: // RQ15
   assert property (@(posedge clk_sys) disable iff (!arst_n)
      !filePtrWrEn |=> $stable(filePtrOut))
   else $error("file pointer changed without a write");

endmodule

/* File: verification/pcs_core_tb.sv */
// self-checking bench for the program counter, return stack and indirect address block
`timescale 1ns/10ps
`include "pcs_consts.svh"
module pcs_core_tb;
   import pcs_pkg::*;
   //--------------------------------------------------------------
   // signals and reference state
   //--------------------------------------------------------------
   logic clk_sys, arst_n, fetchAdvance, pcLowWrEn, pcHoldWrEn, jumpEn, callEn, irqBranch, returnEn;
   logic filePtrWrEn, indirectBankBit, indRdEn, indWrEn, fileRdEn, fileWrEn;
   logic [7:0] pcLowWrData, pcHoldWrData, filePtrWrData, fileRdData, pcLowByte, filePtrOut, indRdData;
   logic [10:0] jumpTarget;
   logic [12:0] progAddr;
   logic [4:0] pcHoldingOut;
   logic [8:0] effAddr;
   int fail_count, n_checks;
   pcs_pc_t pcM;
   pcs_pc_t stackM [8];
   logic [4:0] holdM;
   logic [2:0] spM;
   logic [7:0] fpM, rdM;

   pcs_core pcs_core_i (.clk_sys(clk_sys), .arst_n(arst_n), .fetchAdvance(fetchAdvance), .pcLowWrEn(pcLowWrEn),
      .pcLowWrData(pcLowWrData), .pcHoldWrEn(pcHoldWrEn), .pcHoldWrData(pcHoldWrData), .jumpEn(jumpEn),
      .callEn(callEn), .jumpTarget(jumpTarget), .irqBranch(irqBranch), .returnEn(returnEn),
      .filePtrWrEn(filePtrWrEn), .filePtrWrData(filePtrWrData), .indirectBankBit(indirectBankBit),
      .indRdEn(indRdEn), .indWrEn(indWrEn), .fileRdData(fileRdData), .progAddr(progAddr),
      .pcLowByte(pcLowByte), .pcHoldingOut(pcHoldingOut), .filePtrOut(filePtrOut), .effAddr(effAddr),
      .fileRdEn(fileRdEn), .fileWrEn(fileWrEn), .indRdData(indRdData));

   // 200 MHz core clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   //--------------------------------------------------------------
   // helpers
   //--------------------------------------------------------------
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // reference next state; priority low write, interrupt, branch, return, fetch
   task automatic modelEdge();
      if (pcLowWrEn) pcM = {holdM, pcLowWrData};
      else if (irqBranch)
      begin
         stackM[spM] = pcM;
         spM++;
         pcM = `PCS_IRQ_VEC;
      end
      else if (jumpEn || callEn)
      begin
         if (callEn)
         begin
            stackM[spM] = pcM;
            spM++;
         end
         pcM = {holdM[4:3], jumpTarget};
      end
      else if (returnEn)
      begin
         spM--;
         pcM = stackM[spM];
      end
      else if (fetchAdvance) pcM = pcM + `PCS_PC_STEP;
      if (pcHoldWrEn) holdM = pcHoldWrData[4:0];
      // a read in the same cycle as a pointer write still uses the old pointer
      if (indRdEn) rdM = (fpM == 8'h00) ? 8'h00 : fileRdData;
      if (filePtrWrEn) fpM = filePtrWrData;
   endtask

   // one cycle: check settled registers, drive at falling edge, check comb outputs
   task automatic cycle(input logic [9:0] ev, input logic [7:0] lowD, input logic [7:0] holdD,
                        input logic [10:0] tgt, input logic [7:0] fpD);
      @(negedge clk_sys);
      chk(progAddr, pcM);
      chk(pcLowByte, pcM[7:0]);
      chk(pcHoldingOut, holdM);
      chk(filePtrOut, fpM);
      chk(indRdData, rdM);
      {pcLowWrEn, irqBranch, jumpEn, callEn, returnEn, fetchAdvance, pcHoldWrEn, filePtrWrEn, indRdEn, indWrEn} = ev;
      pcLowWrData = lowD;
      pcHoldWrData = holdD;
      jumpTarget = tgt;
      filePtrWrData = fpD;
      indirectBankBit = 1'($urandom);
      fileRdData = 8'($urandom);
      #1;
      chk(effAddr, {indirectBankBit, fpM});
      chk(fileRdEn, indRdEn && (fpM != 8'h00));
      chk(fileWrEn, indWrEn && (fpM != 8'h00));
      modelEdge();
   endtask

   task automatic rnd(input int n);
      for (int i = 0; i < n; i++)
         cycle(10'($urandom & $urandom & $urandom), 8'($urandom), 8'($urandom), 11'($urandom), 8'($urandom));
   endtask

   task automatic doReset(input int cyc);
      arst_n = 1'b0;
      {pcLowWrEn, irqBranch, jumpEn, callEn, returnEn, fetchAdvance, pcHoldWrEn, filePtrWrEn, indRdEn, indWrEn} = '0;
      pcM = 13'h0000;
      holdM = 5'h00;
      spM = 3'h0;
      fpM = 8'h00;
      rdM = 8'h00;
      #1;
      chk(progAddr, 13'h0000);
      repeat (cyc) @(negedge clk_sys);
      arst_n = 1'b1;
   endtask

   task automatic final_report();
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   //--------------------------------------------------------------
   // main sequence
   //--------------------------------------------------------------
   initial
   begin
      {pcLowWrData, pcHoldWrData, filePtrWrData, fileRdData, jumpTarget, indirectBankBit} = '0;
      fail_count = 0;
      n_checks = 0;
      void'($urandom(32'h930b_8411));
      // start released so the first fall of reset is an edge the design sees
      arst_n = 1'b1;
      #1;
      doReset(16);
      // fill every slot so later pops never return unknowns
      for (int i = 0; i < 8; i++) cycle(10'h040, 8'h00, 8'h00, 11'(i * 3 + 1), 8'h00);
      cycle(10'h008, 8'h00, 8'hff, 11'h000, 8'h00);
      cycle(10'h200, 8'hff, 8'h00, 11'h000, 8'h00);
      cycle(10'h010, 8'h00, 8'h00, 11'h000, 8'h00);
      cycle(10'h100, 8'h00, 8'h00, 11'h000, 8'h00);
      cycle(10'h008, 8'h00, 8'h10, 11'h000, 8'h00);
      // ten calls then ten returns: the ninth and tenth overwrite the oldest
      for (int i = 0; i < 10; i++) cycle(10'h050, 8'h00, 8'h00, 11'(i * 37 + 5), 8'h00);
      for (int i = 0; i < 10; i++) cycle(10'h020, 8'h00, 8'h00, 11'h000, 8'h00);
      cycle(10'h3ff, 8'h5a, 8'h0b, 11'h2a5, 8'h00);
      cycle(10'h0c0, 8'h00, 8'h00, 11'h7ff, 8'h00);
      cycle(10'h004, 8'h00, 8'h00, 11'h000, 8'h00);
      cycle(10'h003, 8'h00, 8'h00, 11'h000, 8'h00);
      cycle(10'h004, 8'h00, 8'h00, 11'h000, 8'hff);
      cycle(10'h003, 8'h00, 8'h00, 11'h000, 8'h00);
      cycle(10'h002, 8'h00, 8'h00, 11'h000, 8'h00);
      cycle(10'h200, 8'h41, 8'h00, 11'h000, 8'h00);
      rnd(3000);
      // idle cycle first so the model and the stack agree before reset
      cycle(10'h000, 8'h00, 8'h00, 11'h000, 8'h00);
      // second reset off the clock edge, half a nanosecond before a rising edge
      #1;
      doReset(3);
      rnd(200);
      cycle(10'h000, 8'h00, 8'h00, 11'h000, 8'h00);
      final_report();
   end
endmodule
